// *** shared/bwc_map.svh ***
`ifndef BWC_MAP_SVH
`define BWC_MAP_SVH

// ****************************************
// configuration offsets
// ****************************************
`define BWC_OFF_PF_BASE_HI  8'h28
`define BWC_OFF_PF_LIMIT_HI 8'h2C
`define BWC_OFF_IO_HI       8'h30
`define BWC_OFF_CAP         8'h34
`define BWC_OFF_INTR_CTL    8'h3C

// ****************************************
// constant and reset values
// ****************************************
`define BWC_CAP_PTR         8'hDC
`define BWC_INT_PIN         8'h00
`define BWC_INT_LINE_RST    8'h00
`define BWC_WORD_RST        32'h0000_0000
`define BWC_HALF_RST        16'h0000
`define BWC_BCTL_RST        3'h0
`define BWC_MEM_LOW_ZERO    20'h0_0000
`define BWC_MEM_LOW_ONES    20'hF_FFFF
`define BWC_IO_LOW_ZERO     12'h000
`define BWC_IO_LOW_ONES     12'hFFF

// ****************************************
// field positions
// ****************************************
`define BWC_BC_LSB          16
`define BWC_BC_PERR         0
`define BWC_BC_SERR         1
`define BWC_BC_ISA          2
`define BWC_IO_LIMIT_LSB    16
`define BWC_INT_PIN_LSB     8
`define BWC_ISA_SPAN_LSB    16
`define BWC_ALIAS_HI        9
`define BWC_ALIAS_LO        8

`endif

// *** shared/bwc_pkg.sv ***
package bwc_pkg;
    typedef logic [31:0] bwc_word_t;
    typedef logic [63:0] bwc_addr_t;
    typedef enum logic {bwc_mem, bwc_io} bwc_space_t;
endpackage

// *** shared/bwc_dec_if.sv ***
`timescale 1ns/1ps
interface bwc_dec_if;
    import bwc_pkg::*;
    bwc_addr_t  pf_base;
    bwc_addr_t  pf_limit;
    bwc_addr_t  io_base;
    bwc_addr_t  io_limit;
    logic       isa_enable;
    bwc_addr_t  down_addr;
    bwc_space_t down_space;
    bwc_addr_t  up_addr;
    bwc_space_t up_space;
    logic       down_hit;
    logic       up_hit;

    modport ctl (output pf_base, pf_limit, io_base, io_limit, isa_enable,
                 down_addr, down_space, up_addr, up_space,
                 input  down_hit, up_hit);
    modport dec (input  pf_base, pf_limit, io_base, io_limit, isa_enable,
                 down_addr, down_space, up_addr, up_space,
                 output down_hit, up_hit);
endinterface

// *** rtl/bwc_window_dec.sv ***
`timescale 1ns/1ps
`include "bwc_map.svh"
module bwc_window_dec
    import bwc_pkg::*;
(
    bwc_dec_if.dec win
);

    function automatic logic in_window(bwc_addr_t a, bwc_addr_t lo, bwc_addr_t hi);
        in_window = (a >= lo) && (a <= hi); // [RQ5]
    endfunction

    // isa alias: first 64KB, last 768 bytes of each 1KB block
    function automatic logic isa_alias(bwc_addr_t a);
        isa_alias = (a[63:`BWC_ISA_SPAN_LSB] == '0) &&
                    (a[`BWC_ALIAS_HI:`BWC_ALIAS_LO] != 2'b00);
    endfunction

    always_comb begin
        if (win.down_space == bwc_io) begin
            win.down_hit = in_window(win.down_addr, win.io_base, win.io_limit) &&
                           !(win.isa_enable && isa_alias(win.down_addr)); // [RQ12] [RQ13]
        end else begin
            win.down_hit = in_window(win.down_addr, win.pf_base, win.pf_limit); // [RQ5]
        end
        if (win.up_space == bwc_io) begin
            win.up_hit = !in_window(win.up_addr, win.io_base, win.io_limit) ||
                         (win.isa_enable && isa_alias(win.up_addr)); // [RQ14]
        end else begin
            win.up_hit = !in_window(win.up_addr, win.pf_base, win.pf_limit);
        end
    end

endmodule

// *** rtl/bwc_top.sv ***
`timescale 1ns/1ps
`include "bwc_map.svh"
// Functional notes
// RQ1: a fully writable 32-bit register holds bits 63:32 of the prefetch window top, reset 0.
// RQ2: a writable 32-bit register holds bits 63:32 of the prefetch bottom, joined to the low base.
// RQ3: a writable 16-bit field holds bits 31:16 of the I/O window bottom, reset 0.
// RQ4: a writable 16-bit field holds bits 31:16 of the I/O window top, reset 0.
// RQ5: a transaction is forwarded only when its full address lies inclusively inside the window.
// RQ6: the capability pointer byte is read-only and always reads DCh.
// RQ7: the interrupt line byte is writable; boot software is expected to write FFh to it.
// RQ8: the interrupt pin byte at bits 15:8 is read-only and shows no pin.
// RQ9: with control bit 16 clear, secondary parity errors are ignored; this is the reset state.
// RQ10: with control bit 16 set, secondary parity errors are detected and reported.
// RQ11: control bit 17 gates the secondary system error onto the primary side, reset 0.
// RQ12: with control bit 18 clear, every in-window I/O address is forwarded without filtering.
// RQ13: with bit 18 set, in-window I/O in the first 64KB hitting the last 768 bytes of 1KB is blocked.
// RQ14: with bit 18 set, secondary I/O in the last 768 bytes of a 1KB block is forwarded upstream; the code does so only in the first 64KB.
module bwc_top
    import bwc_pkg::*;
(
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        cfg_wr,
    input  logic        cfg_rd,
    input  logic [7:0]  cfg_addr,
    input  logic [3:0]  cfg_be,
    input  logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic        cfg_ack,
    input  logic [11:0] pf_base_low,
    input  logic [11:0] pf_limit_low,
    input  logic [3:0]  io_base_low,
    input  logic [3:0]  io_limit_low,
    input  logic        prim_req_valid,
    input  logic [63:0] prim_req_addr,
    input  logic        prim_req_io,
    output logic        fwd_down_valid,
    output logic        fwd_down,
    input  logic        sec_req_valid,
    input  logic [63:0] sec_req_addr,
    input  logic        sec_req_io,
    output logic        fwd_up_valid,
    output logic        fwd_up,
    input  logic        sec_parity_err,
    output logic        sec_parity_report,
    input  logic        secondary_system_error_n,
    output logic        prim_system_error_n
);

    // ****************************************
    // state
    // ****************************************
    bwc_word_t   pf_base_high,  next_pf_base_high;
    bwc_word_t   pf_limit_high, next_pf_limit_high;
    logic [15:0] io_base_high,  next_io_base_high;
    logic [15:0] io_limit_high, next_io_limit_high;
    logic [7:0]  int_line,      next_int_line;
    logic [2:0]  bctl,          next_bctl;
    bwc_word_t   next_cfg_rdata;
    logic        next_cfg_ack;
    logic        next_fwd_down_valid, next_fwd_down;
    logic        next_fwd_up_valid,   next_fwd_up;
    logic        next_sec_parity_report;
    logic        next_prim_system_error_n;

    function automatic bwc_word_t merge_be(bwc_word_t old, bwc_word_t wd, logic [3:0] be);
        merge_be = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge_be[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // ****************************************
    // window decoder
    // ****************************************
    bwc_dec_if win ();

    assign win.pf_base    = {pf_base_high, pf_base_low, `BWC_MEM_LOW_ZERO};   // [RQ2]
    assign win.pf_limit   = {pf_limit_high, pf_limit_low, `BWC_MEM_LOW_ONES}; // [RQ1]
    assign win.io_base    = {32'h0000_0000, io_base_high, io_base_low, `BWC_IO_LOW_ZERO};
    assign win.io_limit   = {32'h0000_0000, io_limit_high, io_limit_low, `BWC_IO_LOW_ONES};
    assign win.isa_enable = bctl[`BWC_BC_ISA];
    assign win.down_addr  = prim_req_addr;
    assign win.down_space = prim_req_io ? bwc_io : bwc_mem;
    assign win.up_addr    = sec_req_addr;
    assign win.up_space   = sec_req_io ? bwc_io : bwc_mem;

    bwc_window_dec u_dec (
        .win (win.dec)
    );

    // ****************************************
    // configuration access
    // ****************************************
    always_comb begin
        bwc_word_t cur;
        cur                = '0;
        next_pf_base_high  = pf_base_high;
        next_pf_limit_high = pf_limit_high;
        next_io_base_high  = io_base_high;
        next_io_limit_high = io_limit_high;
        next_int_line      = int_line;
        next_bctl          = bctl;
        next_cfg_rdata     = cfg_rdata;
        next_cfg_ack       = cfg_wr | cfg_rd;
        case (cfg_addr)
            `BWC_OFF_PF_BASE_HI:  cur = pf_base_high;
            `BWC_OFF_PF_LIMIT_HI: cur = pf_limit_high;
            `BWC_OFF_IO_HI:       cur = {io_limit_high, io_base_high};
            `BWC_OFF_CAP:         cur = {24'h00_0000, `BWC_CAP_PTR}; // [RQ6]
            `BWC_OFF_INTR_CTL:    cur = {13'h0000, bctl, `BWC_INT_PIN, int_line}; // [RQ8]
            default:              cur = '0;
        endcase
        if (cfg_rd) begin
            next_cfg_rdata = cur;
        end
        if (cfg_wr) begin
            case (cfg_addr)
                `BWC_OFF_PF_BASE_HI: begin
                    next_pf_base_high = merge_be(pf_base_high, cfg_wdata, cfg_be); // [RQ2]
                end
                `BWC_OFF_PF_LIMIT_HI: begin
                    next_pf_limit_high = merge_be(pf_limit_high, cfg_wdata, cfg_be); // [RQ1]
                end
                `BWC_OFF_IO_HI: begin
                    cur = merge_be(cur, cfg_wdata, cfg_be);
                    next_io_base_high  = cur[`BWC_IO_LIMIT_LSB-1:0];  // [RQ3]
                    next_io_limit_high = cur[31:`BWC_IO_LIMIT_LSB];   // [RQ4]
                end
                `BWC_OFF_INTR_CTL: begin
                    cur = merge_be(cur, cfg_wdata, cfg_be);
                    next_int_line = cur[7:0];                         // [RQ7]
                    next_bctl     = cur[`BWC_BC_LSB +: 3];            // [RQ9] [RQ11] [RQ12]
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // forwarding and error paths
    // ****************************************
    always_comb begin
        next_fwd_down_valid = prim_req_valid;
        next_fwd_down       = prim_req_valid & win.down_hit; // [RQ5] [RQ13]
        next_fwd_up_valid   = sec_req_valid;
        next_fwd_up         = sec_req_valid & win.up_hit;    // [RQ14]
        next_sec_parity_report = sec_parity_err & bctl[`BWC_BC_PERR]; // [RQ9] [RQ10]
        next_prim_system_error_n =
            ~(~secondary_system_error_n & bctl[`BWC_BC_SERR]);        // [RQ11]
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pf_base_high        <= `BWC_WORD_RST;
            pf_limit_high       <= `BWC_WORD_RST;
            io_base_high        <= `BWC_HALF_RST;
            io_limit_high       <= `BWC_HALF_RST;
            int_line            <= `BWC_INT_LINE_RST;
            bctl                <= `BWC_BCTL_RST;
            cfg_rdata           <= `BWC_WORD_RST;
            cfg_ack             <= 1'b0;
            fwd_down_valid      <= 1'b0;
            fwd_down            <= 1'b0;
            fwd_up_valid        <= 1'b0;
            fwd_up              <= 1'b0;
            sec_parity_report   <= 1'b0;
            prim_system_error_n <= 1'b1;
        end else begin
            pf_base_high        <= next_pf_base_high;
            pf_limit_high       <= next_pf_limit_high;
            io_base_high        <= next_io_base_high;
            io_limit_high       <= next_io_limit_high;
            int_line            <= next_int_line;
            bctl                <= next_bctl;
            cfg_rdata           <= next_cfg_rdata;
            cfg_ack             <= next_cfg_ack;
            fwd_down_valid      <= next_fwd_down_valid;
            fwd_down            <= next_fwd_down;
            fwd_up_valid        <= next_fwd_up_valid;
            fwd_up              <= next_fwd_up;
            sec_parity_report   <= next_sec_parity_report;
            prim_system_error_n <= next_prim_system_error_n;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic prim_alias;
    logic sec_alias;
    logic prim_io_in;
    logic sec_io_in;
    assign prim_alias = (prim_req_addr[63:`BWC_ISA_SPAN_LSB] == '0) &&
                        (prim_req_addr[`BWC_ALIAS_HI:`BWC_ALIAS_LO] != 2'b00);
    assign sec_alias  = (sec_req_addr[63:`BWC_ISA_SPAN_LSB] == '0) &&
                        (sec_req_addr[`BWC_ALIAS_HI:`BWC_ALIAS_LO] != 2'b00);
    assign prim_io_in = (prim_req_addr >= win.io_base) && (prim_req_addr <= win.io_limit);
    assign sec_io_in  = (sec_req_addr >= win.io_base) && (sec_req_addr <= win.io_limit);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_pf_limit_write: assert property ( // [RQ1]
        cfg_wr && cfg_addr == `BWC_OFF_PF_LIMIT_HI && cfg_be == 4'hF
        ##1 cfg_rd && cfg_addr == `BWC_OFF_PF_LIMIT_HI && !cfg_wr
        |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("prefetch limit upper word not read back");
    chk_pf_base_join: assert property ( // [RQ2]
        prim_req_valid && !prim_req_io && prim_req_addr == win.pf_base
        && win.pf_base <= win.pf_limit |=> fwd_down)
        else $error("prefetch base address not forwarded");
    chk_io_base_write: assert property ( // [RQ3]
        cfg_wr && cfg_addr == `BWC_OFF_IO_HI && cfg_be == 4'h3
        |=> win.io_base[31:16] == $past(cfg_wdata[15:0]))
        else $error("io base upper field not written");
    chk_io_limit_write: assert property ( // [RQ4]
        cfg_wr && cfg_addr == `BWC_OFF_IO_HI && cfg_be == 4'hC
        |=> win.io_limit[31:16] == $past(cfg_wdata[31:16]) && $stable(win.io_base))
        else $error("io limit upper field not written alone");
    chk_mem_outside: assert property ( // [RQ5]
        prim_req_valid && !prim_req_io && prim_req_addr > win.pf_limit |=> !fwd_down)
        else $error("address above window forwarded");
    chk_cap_read: assert property ( // [RQ6]
        cfg_rd && cfg_addr == `BWC_OFF_CAP |=> cfg_ack && cfg_rdata[7:0] == `BWC_CAP_PTR)
        else $error("capability pointer wrong");
    chk_int_line_keep: assert property ( // [RQ7]
        cfg_wr && cfg_addr == `BWC_OFF_INTR_CTL && cfg_be[0]
        ##1 (cfg_rd && !cfg_wr && cfg_addr == `BWC_OFF_INTR_CTL)
        |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
        else $error("interrupt line byte lost");
    chk_int_pin_ro: assert property ( // [RQ8]
        cfg_rd && cfg_addr == `BWC_OFF_INTR_CTL
        |=> cfg_rdata[`BWC_INT_PIN_LSB +: 8] == `BWC_INT_PIN)
        else $error("interrupt pin byte not constant");
    chk_parity_off: assert property ( // [RQ9]
        !bctl[`BWC_BC_PERR] |=> !sec_parity_report)
        else $error("parity reported while disabled");
    chk_parity_on: assert property ( // [RQ10]
        bctl[`BWC_BC_PERR] && sec_parity_err |=> sec_parity_report)
        else $error("parity error not reported");
    chk_serr_gate: assert property ( // [RQ11]
        ##1 prim_system_error_n ==
        !(!$past(secondary_system_error_n) && $past(bctl[`BWC_BC_SERR])))
        else $error("system error gating wrong");
    chk_isa_off_fwd: assert property ( // [RQ12]
        prim_req_valid && prim_req_io && !bctl[`BWC_BC_ISA] && prim_io_in |=> fwd_down)
        else $error("in-window io not forwarded");
    chk_isa_block: assert property ( // [RQ13]
        prim_req_valid && prim_req_io && bctl[`BWC_BC_ISA] && prim_alias |=> !fwd_down)
        else $error("isa alias forwarded downstream");
    chk_isa_up: assert property ( // [RQ14]
        sec_req_valid && sec_req_io && bctl[`BWC_BC_ISA] && sec_alias
        |=> fwd_up_valid && fwd_up)
        else $error("isa alias not forwarded upstream");

    cov_mem_down: cover property (prim_req_valid && !prim_req_io ##1 fwd_down);
    cov_isa_block: cover property (prim_req_valid && prim_req_io && prim_io_in
                                   && bctl[`BWC_BC_ISA] && prim_alias);
    cov_io_up: cover property (sec_req_valid && sec_req_io && !sec_io_in ##1 fwd_up);
    cov_serr: cover property (!prim_system_error_n);

endmodule

// *** bench/bwc_sec_agent.sv ***
`timescale 1ns/1ps
// ****************************************
// secondary bus agent model
// ****************************************
module bwc_sec_agent (
    input  wire logic        clk,
    output logic             sec_req_valid,
    output logic [63:0]      sec_req_addr,
    output logic             sec_req_io,
    output logic             sec_parity_err,
    output logic             secondary_system_error_n
);
    initial begin
        sec_req_valid = 1'b0;
        sec_req_addr = 64'h0000_0000_0000_0000;
        sec_req_io = 1'b0;
        sec_parity_err = 1'b0;
        secondary_system_error_n = 1'b1;
    end

    // one request held for one cycle after gap idle cycles; idle lines show the inverse
    task automatic issue(input logic [63:0] addr, input logic io, input int gap);
        @(negedge clk);
        repeat (gap) @(negedge clk);
        sec_req_valid = 1'b1;
        sec_req_addr = addr;
        sec_req_io = io;
        @(negedge clk);
        sec_req_valid = 1'b0;
        sec_req_addr = ~addr;
        sec_req_io = ~io;
    endtask

    // one cycle of parity error and/or system error
    task automatic fault(input logic par, input logic serr);
        @(negedge clk);
        sec_parity_err = par;
        secondary_system_error_n = ~serr;
        @(negedge clk);
        sec_parity_err = 1'b0;
        secondary_system_error_n = 1'b1;
    endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import bwc_pkg::*;
    logic        clk, sys_rst, cfg_wr, cfg_rd, prim_req_valid, prim_req_io;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be, io_base_low, io_limit_low;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [11:0] pf_base_low, pf_limit_low;
    logic [63:0] prim_req_addr, sec_req_addr;
    logic        cfg_ack, fwd_down_valid, fwd_down, sec_req_valid, sec_req_io;
    logic        fwd_up_valid, fwd_up, sec_parity_err, sec_parity_report;
    logic        secondary_system_error_n, prim_system_error_n;
    int          bad_count, checked, cycles;

    bwc_top DUT (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .pf_base_low(pf_base_low), .pf_limit_low(pf_limit_low),
        .io_base_low(io_base_low), .io_limit_low(io_limit_low),
        .prim_req_valid(prim_req_valid), .prim_req_addr(prim_req_addr),
        .prim_req_io(prim_req_io), .fwd_down_valid(fwd_down_valid), .fwd_down(fwd_down),
        .sec_req_valid(sec_req_valid), .sec_req_addr(sec_req_addr), .sec_req_io(sec_req_io),
        .fwd_up_valid(fwd_up_valid), .fwd_up(fwd_up), .sec_parity_err(sec_parity_err),
        .sec_parity_report(sec_parity_report),
        .secondary_system_error_n(secondary_system_error_n),
        .prim_system_error_n(prim_system_error_n));

    bwc_sec_agent partner (.clk(clk), .sec_req_valid(sec_req_valid),
        .sec_req_addr(sec_req_addr), .sec_req_io(sec_req_io),
        .sec_parity_err(sec_parity_err), .secondary_system_error_n(secondary_system_error_n));

    // ****************************************
    // clock, timeout and shared tasks
    // ****************************************
    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            wrap_up();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] data);
        @(negedge clk);
        cfg_wr = wr;
        cfg_rd = ~wr;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = data;
        @(negedge clk);
        check(64'(cfg_ack), 64'h1);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
    endtask

    // full-word write, then a read of the same offset on the very next edge
    task automatic wr_rd(input logic [7:0] addr, input logic [31:0] data,
                         input logic [31:0] exp);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = addr;
        cfg_be = 4'hF;
        cfg_wdata = data;
        @(negedge clk);
        check(64'(cfg_ack), 64'h1);
        cfg_wr = 1'b0;
        cfg_rd = 1'b1;
        @(negedge clk);
        check(64'(cfg_ack), 64'h1);
        check(64'(cfg_rdata), 64'(exp));
        cfg_rd = 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 4'hF, 32'h0000_0000);
        check(64'(cfg_rdata), 64'(exp));
    endtask

    task automatic down(input logic [63:0] addr, input logic io, input logic exp);
        @(negedge clk);
        prim_req_valid = 1'b1;
        prim_req_addr = addr;
        prim_req_io = io;
        @(negedge clk);
        check(64'({fwd_down_valid, fwd_down}), 64'({1'b1, exp}));
        prim_req_valid = 1'b0;
        prim_req_addr = ~addr;
    endtask

    task automatic up(input logic [63:0] addr, input logic io, input int gap, input logic exp);
        partner.issue(addr, io, gap);
        check(64'({fwd_up_valid, fwd_up}), 64'({1'b1, exp}));
    endtask

    task automatic err(input logic par, input logic serr, input logic rep, input logic pn);
        partner.fault(par, serr);
        check(64'({sec_parity_report, prim_system_error_n}), 64'({rep, pn}));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        rd(8'h2C, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        rd(8'h34, 32'h0000_00DC);
        rd(8'h3C, 32'h0000_0000);
        $display("test reset_values done");
    endtask

    task automatic t_registers();
        xfer(1'b1, 8'h2C, 4'hF, 32'h1234_5678);
        xfer(1'b1, 8'h2C, 4'h5, 32'hAABB_CCDD);
        rd(8'h2C, 32'h12BB_56DD);
        wr_rd(8'h2C, 32'h0F0F_F0F0, 32'h0F0F_F0F0);
        xfer(1'b1, 8'h28, 4'hF, 32'h8765_4321);
        rd(8'h28, 32'h8765_4321);
        xfer(1'b1, 8'h30, 4'hF, 32'hA5A5_5A5A);
        rd(8'h30, 32'hA5A5_5A5A);
        xfer(1'b1, 8'h30, 4'h3, 32'h1111_2222);
        rd(8'h30, 32'hA5A5_2222);
        xfer(1'b1, 8'h30, 4'hC, 32'h3333_4444);
        rd(8'h30, 32'h3333_2222);
        xfer(1'b1, 8'h34, 4'hF, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0000_00DC);
        xfer(1'b1, 8'h3C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0007_00FF);
        xfer(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        xfer(1'b1, 8'h3C, 4'h4, 32'h0000_0000);
        rd(8'h3C, 32'h0000_00FF);
        wr_rd(8'h3C, 32'h0000_00FF, 32'h0000_00FF);
        $display("test registers done");
    endtask

    task automatic t_mem_window();
        xfer(1'b1, 8'h28, 4'hF, 32'h0000_0001);
        xfer(1'b1, 8'h2C, 4'hF, 32'h0000_0001);
        pf_base_low = 12'h100;
        pf_limit_low = 12'h1FF;
        down(64'h0000_0001_0FFF_FFFF, 1'b0, 1'b0);
        down(64'h0000_0001_1000_0000, 1'b0, 1'b1);
        down(64'h0000_0001_1FFF_FFFF, 1'b0, 1'b1);
        down(64'h0000_0001_2000_0000, 1'b0, 1'b0);
        down(64'h0000_0000_1000_0000, 1'b0, 1'b0);
        up(64'h0000_0001_1000_0000, 1'b0, 0, 1'b0);
        up(64'h0000_0001_2000_0000, 1'b0, 3, 1'b1);
        $display("test mem_window done");
    endtask

    task automatic t_io_window();
        xfer(1'b1, 8'h30, 4'hF, 32'h0001_0000);
        io_base_low = 4'h1;
        io_limit_low = 4'h2;
        down(64'h0000_0000_0000_0FFF, 1'b1, 1'b0);
        down(64'h0000_0000_0000_1100, 1'b1, 1'b1);
        down(64'h0000_0000_0001_2FFF, 1'b1, 1'b1);
        down(64'h0000_0000_0001_3000, 1'b1, 1'b0);
        up(64'h0000_0000_0000_1100, 1'b1, 0, 1'b0);
        up(64'h0000_0000_0002_0000, 1'b1, 1, 1'b1);
        xfer(1'b1, 8'h3C, 4'h4, 32'h0004_0000);
        down(64'h0000_0000_0000_1100, 1'b1, 1'b0);
        down(64'h0000_0000_0000_13FF, 1'b1, 1'b0);
        down(64'h0000_0000_0000_1000, 1'b1, 1'b1);
        down(64'h0000_0000_0001_0100, 1'b1, 1'b1);
        up(64'h0000_0000_0000_1200, 1'b1, 2, 1'b1);
        up(64'h0000_0000_0000_1000, 1'b1, 0, 1'b0);
        $display("test io_window done");
    endtask

    task automatic t_errors();
        xfer(1'b1, 8'h3C, 4'h4, 32'h0000_0000);
        err(1'b1, 1'b1, 1'b0, 1'b1);
        xfer(1'b1, 8'h3C, 4'h4, 32'h0001_0000);
        err(1'b1, 1'b1, 1'b1, 1'b1);
        err(1'b0, 1'b0, 1'b0, 1'b1);
        xfer(1'b1, 8'h3C, 4'h4, 32'h0003_0000);
        err(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test errors done");
    endtask

    initial begin
        sys_rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
        pf_base_low = 12'h000;
        pf_limit_low = 12'h000;
        io_base_low = 4'h0;
        io_limit_low = 4'h0;
        prim_req_valid = 1'b0;
        prim_req_addr = 64'h0000_0000_0000_0000;
        prim_req_io = 1'b0;
        bad_count = 0;
        checked = 0;
        cycles = 0;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_reset_values();
        t_registers();
        t_mem_window();
        t_io_window();
        t_errors();
        wrap_up();
    end
endmodule
